/* gpr_host_model.sv */
// gpr_host_model: stand-in for the host that asks for the pin settings reply
// assumes: same clock as the block; the bench pulses ask once per request
`timescale 1ns/1ps
module gpr_host_model (
  input  wire logic clk_sys,  // system clock
  input  wire logic rst,      // synchronous reset
  input  wire logic ask,      // bench asks for one request
  output      logic reqStart  // one-cycle request pulse
);
  // registered so the pulse changes only just after an edge and lasts one cycle
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      reqStart <= 1'b0;
    end else begin
      reqStart <= ask;
    end
  end
endmodule : gpr_host_model

/* gpr_pkg.sv */
// gpr_pkg: constants and types for the power-up pin settings readout block
// assumes: one 50 MHz system clock, a plain register port and a reply byte sink
package gpr_pkg;
  // ----------------------------------------------------------------
  // register map (byte addresses, one word each)
  // ----------------------------------------------------------------
  localparam int          ADDR_W      = 8;
  localparam logic [7:0]  OFF_PINCFG  = 8'h00;  // four pin settings bytes
  localparam logic [7:0]  OFF_CLKDIV  = 8'h04;  // clock output divider
  localparam logic [7:0]  OFF_INTCFG  = 8'h08;  // bit1 negative, bit0 positive edge
  localparam logic [7:0]  OFF_INTFLAG = 8'h0c;  // bit0 flag, write 1 clears
  localparam logic [7:0]  OFF_PININ   = 8'h10;  // synchronised pin levels

  // ----------------------------------------------------------------
  // reply layout
  // ----------------------------------------------------------------
  localparam logic [7:0]  CMD_ECHO    = 8'hb0;
  localparam logic [7:0]  STATUS_OK   = 8'h00;
  localparam logic [7:0]  STRUCT_LEN  = 8'h04;
  localparam logic [5:0]  IDX_ECHO    = 6'h00;
  localparam logic [5:0]  IDX_STATUS  = 6'h01;
  localparam logic [5:0]  IDX_LEN     = 6'h02;
  localparam logic [5:0]  IDX_PIN0    = 6'h04;
  localparam logic [5:0]  IDX_LAST    = 6'h3f;
  localparam int          NUM_PINS    = 4;
  localparam int          CFG_W       = 5;      // bits 4-0 of a settings byte

  // ----------------------------------------------------------------
  // designation codes
  // ----------------------------------------------------------------
  localparam logic [2:0]  DES_GPIO    = 3'h0;
  localparam logic [2:0]  DES_DEDIC   = 3'h1;   // suspend / clock / configured / i2c led
  localparam logic [2:0]  DES_ALT0    = 3'h2;   // rx led / analog inputs
  localparam logic [2:0]  DES_ALT1    = 3'h3;   // tx led / analog outputs
  localparam logic [2:0]  DES_ALT2    = 3'h4;   // interrupt detection

  // bit 4 output level, bit 3 direction (1 input), bits 2-0 designation
  typedef struct packed {
    logic       outVal;
    logic       dirIn;
    logic [2:0] desig;
  } gpr_pin_cfg_t;

  localparam gpr_pin_cfg_t PIN_CFG_RST = 5'h08;  // gpio input, level low

  typedef struct packed {
    logic       valid;
    logic       last;
    logic [5:0] idx;
    logic [7:0] data;
  } gpr_reply_t;

  typedef enum logic {
    ST_IDLE = 1'b0,
    ST_SEND = 1'b1
  } gpr_state_t;
endpackage : gpr_pkg

/* gpr_settings_readout.sv */
// gpr_settings_readout: pin settings store, pin multiplexer and 64-byte reply
// assumes: reqStart comes from same-clock command logic; gpIn comes from pads
//
// Our own choices: the strobed register port and the placing of the registers.
`timescale 1ns/1ps
module gpr_settings_readout #(
  parameter int DIV_W = 5
) (
  input  wire logic                clk_sys,          // 50 MHz system clock
  input  wire logic                rst,              // synchronous, active high
  input  wire logic [7:0]          regAddr,          // register byte address
  input  wire logic [31:0]         regWdata,         // register write data
  input  wire logic                regWr,            // write strobe
  input  wire logic                regRd,            // read strobe
  output      logic [31:0]         regRdata,         // read data, cycle after strobe
  input  wire logic                reqStart,         // host read request pulse
  output      gpr_pkg::gpr_reply_t reply,            // reply byte stream
  input  wire logic [3:0]          gpIn,             // pad levels
  output      logic [3:0]          gpOut,            // pad drive levels
  output      logic [3:0]          gpOe,             // pad drive enables
  input  wire logic                suspendIndicator, // suspend state
  input  wire logic                rxActivityLed,    // rx activity
  input  wire logic                txActivityLed,    // tx activity
  input  wire logic                usbConfigured,    // enumeration done
  input  wire logic                i2cActivityLed,   // i2c activity
  output      logic [2:0]          analogInSel,      // pins 1..3 routed to converter inputs
  output      logic [1:0]          analogOutSel      // pins 2..3 routed to converter outputs
);
  // ----------------------------------------------------------------
  // parameter check
  // ----------------------------------------------------------------
  if (DIV_W < 1 || DIV_W > 8) begin : g_bad_div
    $error("DIV_W must be 1 to 8");
  end

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  // ----------------------------------------------------------------
  // register file
  // ----------------------------------------------------------------
  gpr_pkg::gpr_pin_cfg_t [3:0] cfg_q, cfg_d;
  logic [DIV_W-1:0]            div_q, div_d;
  logic [1:0]                  edgeEn_q, edgeEn_d;
  logic                        flag_q, flag_d;
  logic [31:0]                 rdata_q, rdata_d;
  logic [3:0]                  sync2_q;
  logic                        intEvent;

  // writes decode first, the edge event last so a set beats a same-cycle clear
  always_comb begin
    cfg_d    = cfg_q;
    div_d    = div_q;
    edgeEn_d = edgeEn_q;
    flag_d   = flag_q;
    rdata_d  = 32'h0;
    if (regWr) begin
      if (regAddr == gpr_pkg::OFF_PINCFG) begin
        for (int i = 0; i < gpr_pkg::NUM_PINS; i++) begin
          cfg_d[i] = regWdata[8*i +: gpr_pkg::CFG_W];
        end
      end else if (regAddr == gpr_pkg::OFF_CLKDIV) begin
        div_d = regWdata[DIV_W-1:0];
      end else if (regAddr == gpr_pkg::OFF_INTCFG) begin
        edgeEn_d = regWdata[1:0];
      end else if (regAddr == gpr_pkg::OFF_INTFLAG && regWdata[0]) begin
        flag_d = 1'b0;
      end
    end
    if (intEvent) begin
      flag_d = 1'b1;
    end
    if (regRd) begin
      if (regAddr == gpr_pkg::OFF_PINCFG) begin
        for (int i = 0; i < gpr_pkg::NUM_PINS; i++) begin
          rdata_d[8*i +: 8] = {3'h0, cfg_q[i]};
        end
      end else if (regAddr == gpr_pkg::OFF_CLKDIV) begin
        rdata_d[DIV_W-1:0] = div_q;
      end else if (regAddr == gpr_pkg::OFF_INTCFG) begin
        rdata_d[1:0] = edgeEn_q;
      end else if (regAddr == gpr_pkg::OFF_INTFLAG) begin
        rdata_d[0] = flag_q;
      end else if (regAddr == gpr_pkg::OFF_PININ) begin
        rdata_d[3:0] = sync2_q;
      end
    end
  end

  // stored settings come back to their defaults on reset
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      cfg_q    <= {gpr_pkg::NUM_PINS{gpr_pkg::PIN_CFG_RST}};
      div_q    <= '0;
      edgeEn_q <= 2'h0;
      flag_q   <= 1'b0;
      rdata_q  <= 32'h0;
    end else begin
      cfg_q    <= cfg_d;
      div_q    <= div_d;
      edgeEn_q <= edgeEn_d;
      flag_q   <= flag_d;
      rdata_q  <= rdata_d;
    end
  end

  assign regRdata = rdata_q;

  // ----------------------------------------------------------------
  // reply sequencer
  // ----------------------------------------------------------------
  gpr_pkg::gpr_state_t state_q, state_d;
  logic [5:0]          idx_q, idx_d;
  gpr_pkg::gpr_reply_t rep_q, rep_d;
  logic [7:0]          replyByte;

  // content is taken live, so a write during a reply shows in later bytes
  always_comb begin
    replyByte = 8'h0;
    if (idx_q == gpr_pkg::IDX_ECHO) begin
      replyByte = gpr_pkg::CMD_ECHO;
    end else if (idx_q == gpr_pkg::IDX_STATUS) begin
      replyByte = gpr_pkg::STATUS_OK;
    end else if (idx_q == gpr_pkg::IDX_LEN) begin
      replyByte = gpr_pkg::STRUCT_LEN;
    end else if (idx_q >= gpr_pkg::IDX_PIN0 && idx_q < 6'h08) begin
      replyByte = {3'h0, cfg_q[idx_q[1:0]]};
    end
  end

  // a request while a reply is running is ignored
  always_comb begin
    state_d = state_q;
    idx_d   = idx_q;
    rep_d   = '0;
    case (state_q)
      gpr_pkg::ST_IDLE: begin
        if (reqStart) begin
          state_d = gpr_pkg::ST_SEND;
          idx_d   = 6'h0;
        end
      end
      gpr_pkg::ST_SEND: begin
        rep_d.valid = 1'b1;
        rep_d.idx   = idx_q;
        rep_d.data  = replyByte;
        rep_d.last  = (idx_q == gpr_pkg::IDX_LAST);
        idx_d       = idx_q + 6'h1;
        if (idx_q == gpr_pkg::IDX_LAST) begin
          state_d = gpr_pkg::ST_IDLE;
        end
      end
      default: state_d = gpr_pkg::ST_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      state_q <= gpr_pkg::ST_IDLE;
      idx_q   <= 6'h0;
      rep_q   <= '0;
    end else begin
      state_q <= state_d;
      idx_q   <= idx_d;
      rep_q   <= rep_d;
    end
  end

  assign reply = rep_q;

  // ----------------------------------------------------------------
  // pin multiplexer, clock divider, edge detector
  // ----------------------------------------------------------------
  logic [3:0]       sync1_q, sync1_d, sync2_d, prev_q, prev_d;
  logic [DIV_W-1:0] cnt_q, cnt_d;
  logic             clkOut_q, clkOut_d;
  logic [3:0]       out_q, out_d, oe_q, oe_d;
  logic [2:0]       ain_q, ain_d;
  logic [1:0]       aout_q, aout_d;

  // edge seen on the second synchroniser stage against its own delayed copy
  assign intEvent = (cfg_q[1].desig == gpr_pkg::DES_ALT2) &&
                    ((edgeEn_q[1] && prev_q[1] && !sync2_q[1]) ||
                     (edgeEn_q[0] && !prev_q[1] && sync2_q[1]));

  // analog modes release the pad so the converter owns it
  always_comb begin
    sync1_d  = gpIn;
    sync2_d  = sync1_q;
    prev_d   = sync2_q;
    cnt_d    = (cnt_q == div_q) ? '0 : cnt_q + 1'b1;
    clkOut_d = (cnt_q == div_q) ? !clkOut_q : clkOut_q;
    out_d    = 4'h0;
    oe_d     = 4'h0;
    for (int i = 0; i < gpr_pkg::NUM_PINS; i++) begin
      if (cfg_q[i].desig == gpr_pkg::DES_GPIO && !cfg_q[i].dirIn) begin
        oe_d[i]  = 1'b1;
        out_d[i] = cfg_q[i].outVal;
      end
    end
    case (cfg_q[0].desig)
      gpr_pkg::DES_DEDIC: begin oe_d[0] = 1'b1; out_d[0] = suspendIndicator; end
      gpr_pkg::DES_ALT0:  begin oe_d[0] = 1'b1; out_d[0] = rxActivityLed;    end
      default: ;
    endcase
    case (cfg_q[1].desig)
      gpr_pkg::DES_DEDIC: begin oe_d[1] = 1'b1; out_d[1] = clkOut_q;      end
      gpr_pkg::DES_ALT1:  begin oe_d[1] = 1'b1; out_d[1] = txActivityLed; end
      default: ;
    endcase
    if (cfg_q[2].desig == gpr_pkg::DES_DEDIC) begin
      oe_d[2]  = 1'b1;
      out_d[2] = usbConfigured;
    end
    if (cfg_q[3].desig == gpr_pkg::DES_DEDIC) begin
      oe_d[3]  = 1'b1;
      out_d[3] = i2cActivityLed;
    end
    ain_d  = {cfg_q[3].desig == gpr_pkg::DES_ALT0, cfg_q[2].desig == gpr_pkg::DES_ALT0,
              cfg_q[1].desig == gpr_pkg::DES_ALT0};
    aout_d = {cfg_q[3].desig == gpr_pkg::DES_ALT1, cfg_q[2].desig == gpr_pkg::DES_ALT1};
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      sync1_q  <= 4'h0;
      sync2_q  <= 4'h0;
      prev_q   <= 4'h0;
      cnt_q    <= '0;
      clkOut_q <= 1'b0;
      out_q    <= 4'h0;
      oe_q     <= 4'h0;
      ain_q    <= 3'h0;
      aout_q   <= 2'h0;
    end else begin
      sync1_q  <= sync1_d;
      sync2_q  <= sync2_d;
      prev_q   <= prev_d;
      cnt_q    <= cnt_d;
      clkOut_q <= clkOut_d;
      out_q    <= out_d;
      oe_q     <= oe_d;
      ain_q    <= ain_d;
      aout_q   <= aout_d;
    end
  end

  assign gpOut        = out_q;
  assign gpOe         = oe_q;
  assign analogInSel  = ain_q;
  assign analogOutSel = aout_q;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  sequence seqHead;
    reply.valid && reply.idx == 6'h00 && reply.data == 8'hb0 ##1
    reply.valid && reply.idx == 6'h01 && reply.data == 8'h00 ##1
    reply.valid && reply.idx == 6'h02 && reply.data == gpr_pkg::STRUCT_LEN;
  endsequence

  a_reply_head:    assert property (reqStart && state_q == gpr_pkg::ST_IDLE |=> ##1 seqHead)
    else $error("reply header wrong");
  a_reply_end:     assert property (reqStart && state_q == gpr_pkg::ST_IDLE |=> ##64 reply.last && reply.valid)
    else $error("reply does not end on byte 63");
  a_reply_pad:     assert property (reply.valid && reply.idx >= 6'h08 |-> reply.data == 8'h00)
    else $error("pad byte not zero");
  a_settings_byte: assert property (reply.valid && reply.idx == 6'h05 |-> reply.data[7:5] == 3'h0
                                    && reply.data[4:0] == $past(cfg_q[1]))
    else $error("pin one settings byte wrong");
  a_pin0_suspend:  assert property (cfg_q[0].desig == 3'h1 |=> gpOe[0] && gpOut[0] == $past(suspendIndicator))
    else $error("suspend indicator not on pin zero");
  a_pin2_config:   assert property (cfg_q[2].desig == 3'h1 |=> gpOe[2] && gpOut[2] == $past(usbConfigured))
    else $error("configured indicator not on pin two");
  a_pin3_i2c:      assert property (cfg_q[3].desig == 3'h1 |=> gpOe[3] && gpOut[3] == $past(i2cActivityLed))
    else $error("i2c led not on pin three");
  // the pin must stay in clock mode across the toggle, or a mode change would look like a missed edge
  a_clk_toggle:    assert property (cfg_q[1].desig == 3'h1 && cnt_q == div_q ##1 cfg_q[1].desig == 3'h1
                                    |=> gpOut[1] != $past(gpOut[1]))
    else $error("clock output did not toggle");
  a_int_fall:      assert property (cfg_q[1].desig == 3'h4 && edgeEn_q[1] && $fell(sync2_q[1]) |=> flag_q)
    else $error("falling edge not flagged");
  a_int_rise:      assert property (cfg_q[1].desig == 3'h4 && edgeEn_q[0] && $rose(sync2_q[1]) |=> flag_q)
    else $error("rising edge not flagged");

  for (genvar g = 0; g < gpr_pkg::NUM_PINS; g++) begin : g_chk
    a_gpio_drive: assert property (cfg_q[g].desig == 3'h0 && !cfg_q[g].dirIn
                                   |=> gpOe[g] && gpOut[g] == $past(cfg_q[g].outVal))
      else $error("gpio output level wrong");
    a_gpio_input: assert property (cfg_q[g].desig == 3'h0 && cfg_q[g].dirIn |=> !gpOe[g])
      else $error("gpio input pin driven");
  end
endmodule : gpr_settings_readout

/* tb_gp_powerup_settings_readout.sv */
// tb_gp_powerup_settings_readout: self-checking bench for the pin settings readout
// assumes: gpr_pkg and gpr_settings_readout are compiled first
`timescale 1ns/1ps
module tb_gp_powerup_settings_readout;
  logic                clk_sys = 1'b0, rst = 1'b1, regWr = 1'b0, regRd = 1'b0, ask = 1'b0;
  logic                reqStart, rdSeen = 1'b0;
  logic [7:0]          regAddr = 8'h00;
  logic [31:0]         regWdata = 32'h0, regRdata, v;
  logic [3:0]          gpIn = 4'h0, gpOut, gpOe, eo, ev;
  logic [4:0]          route = 5'h00;
  logic [2:0]          analogInSel, d;
  logic [1:0]          analogOutSel;
  gpr_pkg::gpr_reply_t reply;
  logic [31:0]         rdQ[$];
  gpr_pkg::gpr_reply_t repQ[$];
  int                  bad_count = 0, comparisons = 0, k;

  always #10 clk_sys = ~clk_sys;

  gpr_host_model host (.clk_sys(clk_sys), .rst(rst), .ask(ask), .reqStart(reqStart));
  gpr_settings_readout dut (.clk_sys(clk_sys), .rst(rst), .regAddr(regAddr), .regWdata(regWdata),
    .regWr(regWr), .regRd(regRd), .regRdata(regRdata), .reqStart(reqStart), .reply(reply),
    .gpIn(gpIn), .gpOut(gpOut), .gpOe(gpOe), .suspendIndicator(route[0]), .rxActivityLed(route[1]),
    .txActivityLed(route[2]), .usbConfigured(route[3]), .i2cActivityLed(route[4]),
    .analogInSel(analogInSel), .analogOutSel(analogOutSel));

  // ----------------------------------------------------------------
  // compare and bus tasks
  // ----------------------------------------------------------------
  task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
    comparisons++;
    if (g !== e) begin
      bad_count++;
      $display("unexpected %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic chkRep(gpr_pkg::gpr_reply_t e, gpr_pkg::gpr_reply_t g);
    comparisons++;
    if (g !== e) begin
      bad_count++;
      $display("unexpected reply expected %h seen %h", e, g);
    end
  endtask : chkRep
  task automatic wr(logic [7:0] a, logic [31:0] dat);
    @(posedge clk_sys);
    regWr    <= 1'b1;
    regAddr  <= a;
    regWdata <= dat;
    @(posedge clk_sys);
    regWr <= 1'b0;
  endtask : wr
  task automatic rd(logic [7:0] a, logic [31:0] e);
    @(posedge clk_sys);
    regRd   <= 1'b1;
    regAddr <= a;
    rdQ.push_back(e);
    @(posedge clk_sys);
    regRd <= 1'b0;
  endtask : rd
  task automatic settle;
    repeat (3) @(posedge clk_sys);
    #1;
  endtask : settle
  // a second request mid-reply must add no bytes: the monitor flags any surplus
  task automatic askReply(logic [31:0] s);
    for (int i = 0; i < 64; i++) begin
      repQ.push_back({1'b1, i == 63, 6'(i), i == 0 ? gpr_pkg::CMD_ECHO : i == 2 ? gpr_pkg::STRUCT_LEN :
        (i >= 4 && i < 8) ? {3'h0, s[8*(i-4)+:5]} : 8'h00});
    end
    @(posedge clk_sys);
    ask <= 1'b1;
    @(posedge clk_sys);
    ask <= 1'b0;
    repeat (10) @(posedge clk_sys);
    ask <= 1'b1;
    @(posedge clk_sys);
    ask <= 1'b0;
    for (k = 0; k < 200 && repQ.size() != 0; k++) @(posedge clk_sys);
    repeat (5) @(posedge clk_sys);
    chk("reply bytes left", 0, repQ.size());
  endtask : askReply
  task automatic waitPin(logic lvl);
    for (k = 0; k < 50 && gpOut[1] !== lvl; k++) @(posedge clk_sys);
  endtask : waitPin
  task automatic print_verdict;
    $display("comparisons %0d mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : print_verdict

  // monitor: read data one cycle after the strobe, reply bytes whenever valid
  // the reply is unknown until the first reset edge, so it is only watched out of reset
  always @(posedge clk_sys) begin
    if (rdSeen) chk("regRdata", rdQ.pop_front(), regRdata);
    rdSeen <= regRd;
    if (!rst && reply.valid !== 1'b0) chkRep(repQ.size() ? repQ.pop_front() : '0, reply);
  end

  // watchdog sized well above the several hundred cycles the tests need
  initial begin
    repeat (30000) @(posedge clk_sys);
    bad_count++;
    print_verdict();
  end

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    void'($urandom(32844));
    repeat (16) @(posedge clk_sys);
    rst <= 1'b0;
    settle();
    chk("gpOe", 4'h0, gpOe);
    rd(gpr_pkg::OFF_PINCFG, 32'h08080808);
    wr(8'h20, 32'hffffffff);
    rd(8'h20, 32'h0);
    rd(gpr_pkg::OFF_PINCFG, 32'h08080808);
    $display("test reset done");
    // random settings: every designation code on every pin except clock mode on pin one, random spare bits
    for (int it = 0; it < 40; it++) begin
      v = $urandom();
      if (v[10:8] == 3'h1) v[10:8] = 3'h0;
      @(posedge clk_sys);
      route <= 5'($urandom());
      wr(gpr_pkg::OFF_PINCFG, v);
      settle();
      for (int p = 0; p < 4; p++) begin
        d = v[8*p+:3];
        eo[p] = (d == 3'h0) && !v[8*p+3];
        ev[p] = v[8*p+4];
        case ({2'(p), d})
          5'h01: {eo[p], ev[p]} = {1'b1, route[0]};
          5'h02: {eo[p], ev[p]} = {1'b1, route[1]};
          5'h0b: {eo[p], ev[p]} = {1'b1, route[2]};
          5'h11: {eo[p], ev[p]} = {1'b1, route[3]};
          5'h19: {eo[p], ev[p]} = {1'b1, route[4]};
          default: ;
        endcase
      end
      chk("gpOe", eo, gpOe);
      chk("gpOut", ev & eo, gpOut & gpOe);
      chk("analogInSel", {v[26:24] == 3'h2, v[18:16] == 3'h2, v[10:8] == 3'h2}, analogInSel);
      chk("analogOutSel", {v[26:24] == 3'h3, v[18:16] == 3'h3}, analogOutSel);
      rd(gpr_pkg::OFF_PINCFG, v & 32'h1f1f1f1f);
      if (it % 8 == 0) askReply(v);
    end
    $display("test settings done");
    // clock output on pin one, divider 3: four cycles high, four low
    wr(gpr_pkg::OFF_CLKDIV, 32'h3);
    rd(gpr_pkg::OFF_CLKDIV, 32'h3);
    wr(gpr_pkg::OFF_PINCFG, 32'h08080108);
    settle();
    chk("gpOe", 4'h2, gpOe);
    waitPin(1'b0);
    waitPin(1'b1);
    waitPin(1'b0);
    chk("clock high span", 4, k);
    waitPin(1'b1);
    chk("clock low span", 4, k);
    $display("test clock done");
    // edge detection on pin one, falling enabled first, then rising
    wr(gpr_pkg::OFF_PINCFG, 32'h08080408);
    wr(gpr_pkg::OFF_INTCFG, 32'h2);
    rd(gpr_pkg::OFF_INTCFG, 32'h2);
    gpIn <= 4'h2;
    repeat (8) @(posedge clk_sys);
    rd(gpr_pkg::OFF_PININ, 32'h2);
    rd(gpr_pkg::OFF_INTFLAG, 32'h0);
    gpIn <= 4'h0;
    repeat (8) @(posedge clk_sys);
    rd(gpr_pkg::OFF_INTFLAG, 32'h1);
    wr(gpr_pkg::OFF_INTFLAG, 32'h1);
    rd(gpr_pkg::OFF_INTFLAG, 32'h0);
    wr(gpr_pkg::OFF_INTCFG, 32'h1);
    gpIn <= 4'h2;
    repeat (8) @(posedge clk_sys);
    rd(gpr_pkg::OFF_INTFLAG, 32'h1);
    chk("gpOe", 4'h0, gpOe);
    $display("test edge detect done");
    repeat (4) @(posedge clk_sys);
    print_verdict();
  end
endmodule : tb_gp_powerup_settings_readout
